// File: core/lam_pkg.sv
// Package for the logical address mapper: register map, fields and carriers.
package lam_pkg;
  // Register byte offsets; map and page-protect blocks are 16 words each.
  localparam logic [7:0] LAM_OFF_PSW1 = 8'h00;
  localparam logic [7:0] LAM_OFF_PSW2 = 8'h04;
  localparam logic [7:0] LAM_OFF_OLD = 8'h08;
  localparam logic [1:0] LAM_BLK_MAP = 2'h1;
  localparam logic [1:0] LAM_BLK_PROT = 2'h2;
  // Status word one, numbered from the lsb as bit 0.
  localparam int LAM_P1_PRIVILEGED_FLAG = 31;
  localparam int LAM_P1_CC_HI = 30;
  localparam int LAM_P1_CC_LO = 27;
  localparam int LAM_P1_EXT = 26;
  localparam int LAM_P1_LAST_RIGHT_HALFWORD_FLAG = 25;
  localparam int LAM_P1_ARITH_TRAP_MASK = 24;
  localparam int LAM_P1_SDW = 23;
  localparam int LAM_P1_MAPD = 22;
  localparam int LAM_P1_RSV_HI = 21;
  localparam int LAM_P1_RSV_LO = 19;
  localparam int LAM_P1_PC_HI = 18;
  localparam int LAM_P1_PC_LO = 2;
  localparam int LAM_P1_NR = 1;
  localparam int LAM_P1_BLK = 0;
  // Bits 0, 22 and 23 exist only in the displayed word.
  localparam logic [31:0] LAM_P1_DISP_MASK = 32'h00c0_0001;
  localparam logic [31:0] LAM_P1_RSV_MASK = 32'h0038_0000;
  localparam logic [31:0] LAM_P1_RESET = 32'h8000_0000;
  // Status word two.
  localparam int LAM_P2_MODE_HI = 31;
  localparam int LAM_P2_MODE_LO = 30;
  localparam int LAM_P2_BASE_PROCESS_INDEX_HI = 29;
  localparam int LAM_P2_BASE_PROCESS_INDEX_LO = 18;
  localparam logic [31:0] LAM_P2_RESET = 32'h0000_0000;
  localparam logic [1:0] LAM_MODE_UNMAPPED = 2'h0;
  // Page entry layout.
  localparam int LAM_PE_VALID = 15;
  localparam int LAM_PE_PROT = 14;
  localparam int LAM_PE_PPN_HI = 11;
  localparam int LAM_PE_PPN_LO = 0;
  localparam logic [15:0] LAM_PE_RESET = 16'h0000;
  // Address geometry.
  localparam int LAM_LADDR_W = 19;
  localparam int LAM_PADDR_W = 24;
  localparam int LAM_PAGE_OFS_W = 15;
  localparam int LAM_PPN_USED_W = 9;
  localparam int LAM_PROT_PG_HI = 18;
  localparam int LAM_PROT_PG_LO = 11;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic use_index;
    logic bit_op;
    logic [2:0] bit_sel;
    logic ext_space;
    logic [18:0] laddr;
  } lam_req_s;

  typedef struct packed {
    logic valid;
    logic granted;
    logic prot_fault;
    logic page_fault;
    logic fetch_fault;
    logic [23:0] paddr;
    logic [7:0] bit_mask;
  } lam_resp_s;
endpackage : lam_pkg

// File: core/lam_mapper.sv
// Logical address mapper: translation, write protection and status words.
`timescale 1ns/1ps
module lam_mapper (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Processor address path
  input wire lam_pkg::lam_req_s req_i,
  input wire logic [31:0] index_i,
  output lam_pkg::lam_resp_s resp_o,
  // Branch and status events
  input wire logic br_valid_i,
  input wire logic br_indirect_i,
  input wire logic [18:0] br_target_i,
  input wire logic [31:0] br_ind_word_i,
  input wire logic save_old_i,
  input wire logic last_right_i,
  input wire logic arith_exc_i,
  input wire logic blocked_i,
  input wire logic sdw_mode_i,
  // Status outputs
  output logic privileged_flag_o,
  output logic extended_index_enable_o,
  output logic next_right_halfword_flag_o,
  output logic mapped_o,
  output logic [11:0] base_process_index_o,
  output logic arith_trap_o,
  output logic [31:0] psw1_mem_o
);
  import lam_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] psw1_q;
  logic [31:0] psw2_q;
  logic [31:0] old_q;
  logic [15:0] map_q [32];
  logic [15:0] prot_q [16];
  logic mapped;
  logic ext_on;
  logic privileged_flag;
  lam_resp_s resp_d;

  // Word index into the map or protect block.
  function automatic logic [3:0] lam_word(input logic [7:0] a);
    return a[5:2];
  endfunction : lam_word

  // Block selector: 1 for the map, 2 for the page-protect registers.
  function automatic logic [1:0] lam_blk(input logic [7:0] a);
    return a[7:6];
  endfunction : lam_blk

  // Displayed first status word, with live-only bits filled in.
  function automatic logic [31:0] lam_disp(input logic [31:0] p,
                                           input logic s, input logic m,
                                           input logic b);
    logic [31:0] r;
    r = p & ~LAM_P1_DISP_MASK;
    r[LAM_P1_SDW] = s;
    r[LAM_P1_MAPD] = m;
    r[LAM_P1_BLK] = b;
    return r;
  endfunction : lam_disp

  assign mapped =
    psw2_q[LAM_P2_MODE_HI:LAM_P2_MODE_LO] != LAM_MODE_UNMAPPED;
  assign ext_on = psw1_q[LAM_P1_EXT];
  assign privileged_flag = psw1_q[LAM_P1_PRIVILEGED_FLAG];

  ////////////////////////////////////////////////////////////////////////////
  // Status word one: bus writes, then branches, which win on the pc field.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psw1_q <= LAM_P1_RESET;
    end else if (en_i) begin
      if (reg_we_i && reg_addr_i == LAM_OFF_PSW1) begin
        psw1_q <= reg_wdata_i & ~LAM_P1_DISP_MASK &
                  ~LAM_P1_RSV_MASK;
      end
      if (br_valid_i) begin
        psw1_q[LAM_P1_PC_HI:LAM_P1_NR] <= br_target_i[18:1];
        if (br_indirect_i) begin
          psw1_q[LAM_P1_CC_HI:LAM_P1_CC_LO] <=
            br_ind_word_i[LAM_P1_CC_HI:LAM_P1_CC_LO];
        end
      end
    end
  end

  // Status word two; a switch to unmapped never touches the map itself.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psw2_q <= LAM_P2_RESET;
    end else if (en_i && reg_we_i && reg_addr_i == LAM_OFF_PSW2) begin
      psw2_q <= reg_wdata_i;
    end
  end

  // Saved old status word carries the last-right-halfword history bit.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      old_q <= 32'h0000_0000;
    end else if (en_i && save_old_i) begin
      old_q <= psw1_q & ~LAM_P1_DISP_MASK;
      old_q[LAM_P1_LAST_RIGHT_HALFWORD_FLAG] <= last_right_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Map words: even page in the upper half, odd page in the lower half.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 32; i++) begin
        map_q[i] <= LAM_PE_RESET;
      end
    end else if (en_i && reg_we_i &&
                 lam_blk(reg_addr_i) == LAM_BLK_MAP) begin
      map_q[{lam_word(reg_addr_i), 1'b0}] <= reg_wdata_i[31:16];
      map_q[{lam_word(reg_addr_i), 1'b1}] <= reg_wdata_i[15:0];
    end
  end

  // Page-protect registers, one bit for each 512-word page.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 16; i++) begin
        prot_q[i] <= 16'h0000;
      end
    end else if (en_i && reg_we_i &&
                 lam_blk(reg_addr_i) == LAM_BLK_PROT) begin
      prot_q[lam_word(reg_addr_i)] <= reg_wdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads answer one cycle later; unmapped offsets read zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (en_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_re_i) begin
        if (reg_addr_i == LAM_OFF_PSW1) begin
          reg_rdata_o <= lam_disp(psw1_q, sdw_mode_i, mapped,
                                  blocked_i);
        end else if (reg_addr_i == LAM_OFF_PSW2) begin
          reg_rdata_o <= psw2_q;
        end else if (reg_addr_i == LAM_OFF_OLD) begin
          reg_rdata_o <= old_q;
        end else if (lam_blk(reg_addr_i) == LAM_BLK_MAP) begin
          reg_rdata_o <= {map_q[{lam_word(reg_addr_i), 1'b0}],
                          map_q[{lam_word(reg_addr_i), 1'b1}]};
        end else if (lam_blk(reg_addr_i) == LAM_BLK_PROT) begin
          reg_rdata_o <= {16'h0000, prot_q[lam_word(reg_addr_i)]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Translation and protection, decided in one cycle.
  always_comb begin
    logic [4:0] page;
    logic [15:0] ent;
    logic [23:0] pa;
    logic [7:0] pg;
    logic wprot;
    page = {req_i.ext_space, req_i.laddr[18:15]};
    ent = map_q[page];
    pa = {5'h00, req_i.laddr};
    pg = 8'h00;
    wprot = 1'b0;
    resp_d = '0;
    resp_d.valid = req_i.valid;
    if (mapped) begin
      pa = {ent[LAM_PE_PPN_LO +: LAM_PPN_USED_W],
            req_i.laddr[LAM_PAGE_OFS_W-1:0]};
      resp_d.page_fault = !ent[LAM_PE_VALID] ||
                          (req_i.ext_space && !ext_on);
      resp_d.fetch_fault = req_i.fetch && req_i.ext_space;
      wprot = ent[LAM_PE_PROT];
    end else begin
      if (ext_on && req_i.use_index) begin
        pa = index_i[23:0] + {5'h00, req_i.laddr};
      end
      resp_d.fetch_fault = req_i.fetch && pa[23:19] != 5'h00;
      pg = pa[LAM_PROT_PG_HI:LAM_PROT_PG_LO];
      wprot = pa[23:19] == 5'h00 && prot_q[pg[7:4]][pg[3:0]];
    end
    resp_d.prot_fault = req_i.write && wprot && !privileged_flag;
    resp_d.paddr = pa;
    resp_d.bit_mask = req_i.bit_op ? 8'h80 >> req_i.bit_sel : 8'h00;
    resp_d.granted = req_i.valid && !resp_d.page_fault &&
                     !resp_d.fetch_fault && !resp_d.prot_fault;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_o <= '0;
    end else if (en_i) begin
      resp_o <= resp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs, all registered.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      privileged_flag_o <= 1'b0;
      extended_index_enable_o <= 1'b0;
      next_right_halfword_flag_o <= 1'b0;
      mapped_o <= 1'b0;
      base_process_index_o <= 12'h000;
      arith_trap_o <= 1'b0;
      psw1_mem_o <= 32'h0000_0000;
    end else if (en_i) begin
      privileged_flag_o <= privileged_flag;
      extended_index_enable_o <= ext_on;
      next_right_halfword_flag_o <= psw1_q[LAM_P1_NR];
      mapped_o <= mapped;
      base_process_index_o <= psw2_q[LAM_P2_BASE_PROCESS_INDEX_HI:LAM_P2_BASE_PROCESS_INDEX_LO];
      arith_trap_o <= arith_exc_i && psw1_q[LAM_P1_ARITH_TRAP_MASK];
      psw1_mem_o <= psw1_q & ~LAM_P1_DISP_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks. The core holds its state while en_i is low; all checks but a_reserved_zero qualify on en_i.
  a_unmapped_direct: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && req_i.valid && !mapped && !ext_on ##1 en_i |->
      resp_o.paddr == {5'h00, $past(req_i.laddr)})
    else $error("unmapped address not passed through");

  a_bit_select: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && req_i.bit_op ##1 en_i |->
      resp_o.bit_mask == (8'h80 >> $past(req_i.bit_sel)))
    else $error("bit mask does not match register field");

  a_ext_index: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && !mapped && ext_on && req_i.use_index ##1 en_i |->
      resp_o.paddr == $past(index_i[23:0]) + {5'h00, $past(req_i.laddr)})
    else $error("extended index sum wrong");

  a_high_fetch: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && req_i.valid ##1 en_i && !$past(mapped) && $past(req_i.fetch) &&
      resp_o.paddr[23:19] != 5'h00 |-> resp_o.fetch_fault && !resp_o.granted)
    else $error("fetch above first 512 KB not refused");

  a_ext_fetch: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && mapped && req_i.fetch && req_i.ext_space ##1 en_i |->
      !resp_o.granted)
    else $error("fetch from extended operand page granted");

  a_map_protect: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && mapped && req_i.write && !privileged_flag &&
      map_q[{req_i.ext_space, req_i.laddr[18:15]}][LAM_PE_PROT] ##1 en_i |->
      resp_o.prot_fault)
    else $error("write to protected page not blocked");

  a_privileged_flag_override: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && privileged_flag ##1 en_i |-> !resp_o.prot_fault)
    else $error("privileged write flagged");

  a_branch_pc: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && br_valid_i |=>
      psw1_q[LAM_P1_PC_HI:LAM_P1_NR] == $past(br_target_i[18:1]) ##1
      !en_i || next_right_halfword_flag_o == $past(br_target_i[1], 2))
    else $error("branch target not loaded");

  a_reserved_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (psw1_q & LAM_P1_RSV_MASK) == 32'h0000_0000)
    else $error("reserved status bits set");

  a_store_copy: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i |=> (psw1_mem_o & LAM_P1_DISP_MASK) == 32'h0000_0000)
    else $error("display-only bits in stored copy");

  a_trap_mask: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && arith_exc_i && !psw1_q[LAM_P1_ARITH_TRAP_MASK] |=> !arith_trap_o)
    else $error("masked arithmetic trap raised");

  a_mode_decode: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i |=> mapped_o == ($past(psw2_q[31:30]) != 2'h0))
    else $error("map mode decode wrong");

  a_page_valid: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && mapped && req_i.valid &&
      !map_q[{req_i.ext_space, req_i.laddr[18:15]}][LAM_PE_VALID] ##1 en_i |->
      resp_o.page_fault && !resp_o.granted)
    else $error("access through invalid page granted");

  a_mapped_addr: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && mapped && req_i.valid ##1 en_i |->
      resp_o.paddr[LAM_PAGE_OFS_W-1:0] ==
      $past(req_i.laddr[LAM_PAGE_OFS_W-1:0]))
    else $error("mapped page offset altered");

  a_cc_indirect: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && br_valid_i && br_indirect_i |=>
      psw1_q[LAM_P1_CC_HI:LAM_P1_CC_LO] ==
      $past(br_ind_word_i[LAM_P1_CC_HI:LAM_P1_CC_LO]))
    else $error("indirect branch condition codes not copied");

  a_old_history: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && save_old_i |=> old_q[LAM_P1_LAST_RIGHT_HALFWORD_FLAG] == $past(last_right_i))
    else $error("history bit not saved");

  a_map_kept: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    en_i && reg_we_i && reg_addr_i == LAM_OFF_PSW2 |=>
      map_q[0] == $past(map_q[0]) && map_q[31] == $past(map_q[31]))
    else $error("status load disturbed the map");
endmodule : lam_mapper

// File: bench/lam_mem_model.sv
// Memory side model: counts the accesses that the mapper grants.
`timescale 1ns/1ps
module lam_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Mapper response
  input wire lam_pkg::lam_resp_s resp_i,
  // Access count
  output logic [15:0] grant_cnt_o
);
  import lam_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Faulted cycles never start a memory cycle, so only grants are counted.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grant_cnt_o <= 16'h0000;
    end else if (resp_i.valid && resp_i.granted) begin
      grant_cnt_o <= grant_cnt_o + 16'h0001;
    end
  end
endmodule : lam_mem_model

// File: bench/test_lam_mapper.sv
// Self-checking bench for the logical address mapper.
`timescale 1ns/1ps
module test_lam_mapper;
  import lam_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  lam_req_s req_i = '0;
  logic [31:0] index_i = 32'h0;
  lam_resp_s resp_o;
  logic br_valid_i = 1'b0;
  logic br_indirect_i = 1'b0;
  logic [18:0] br_target_i = 19'h0;
  logic [31:0] br_ind_word_i = 32'h0;
  logic save_old_i = 1'b0;
  logic last_right_i = 1'b0;
  logic arith_exc_i = 1'b0;
  logic blocked_i = 1'b0;
  logic sdw_mode_i = 1'b0;
  logic privileged_flag_o;
  logic extended_index_enable_o;
  logic next_right_halfword_flag_o;
  logic mapped_o;
  logic [11:0] base_process_index_o;
  logic arith_trap_o;
  logic [31:0] psw1_mem_o;
  logic [15:0] grant_cnt;
  logic rd_seen = 1'b0;
  logic [18:0] la;
  lam_req_s r;
  int errors = 0;
  int cmp_count = 0;
  int seed = 68017;
  int exp_grants = 0;
  logic [31:0] exp_rd[$];
  lam_resp_s exp_rsp[$];
  localparam logic [3:0] G = 4'h8, PR = 4'h4, PG = 4'h2, FF = 4'h1;

  lam_mapper i_lam_mapper (.clk_i, .rst_n_i, .en_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .req_i, .index_i,
    .resp_o, .br_valid_i, .br_indirect_i, .br_target_i, .br_ind_word_i,
    .save_old_i, .last_right_i, .arith_exc_i, .blocked_i, .sdw_mode_i,
    .privileged_flag_o, .extended_index_enable_o,
    .next_right_halfword_flag_o, .mapped_o, .base_process_index_o,
    .arith_trap_o, .psw1_mem_o);
  lam_mem_model i_lam_mem_model (.clk_i, .rst_n_i, .resp_i(resp_o),
    .grant_cnt_o(grant_cnt));

  always #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t value %h expected %h", $time, g, e);
    end
  endtask : chk32

  // Fault responses carry no meaningful address, so paddr is skipped there.
  task automatic chk_rsp(input lam_resp_s g, input lam_resp_s e);
    cmp_count++;
    if (g.granted !== e.granted || g.prot_fault !== e.prot_fault ||
        g.page_fault !== e.page_fault || g.fetch_fault !== e.fetch_fault ||
        (e.granted && g.paddr !== e.paddr) ||
        g.valid !== e.valid || g.bit_mask !== e.bit_mask) begin
      errors++;
      $display("ERROR %0t response %h expected %h", $time, g, e);
    end
  endtask : chk_rsp

  task automatic end_of_test;
    if (exp_rd.size() + exp_rsp.size() != 0) begin
      errors++;
    end
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
  endtask : rd

  function automatic lam_req_s mkq(input logic [3:0] k, input logic [18:0] a);
    lam_req_s q;
    q = '0;
    {q.fetch, q.write, q.use_index, q.ext_space} = k;
    q.laddr = a;
    return q;
  endfunction : mkq

  task automatic xl(input lam_req_s q, input logic [3:0] f,
                    input logic [23:0] pa, input logic [7:0] m);
    lam_resp_s e;
    e = '0;
    e.valid = 1'b1;
    {e.granted, e.prot_fault, e.page_fault, e.fetch_fault} = f;
    e.paddr = pa;
    e.bit_mask = m;
    exp_rsp.push_back(e);
    exp_grants += int'(f[3]);
    q.valid = 1'b1;
    @(posedge clk_i);
    req_i <= q;
    @(posedge clk_i);
    req_i <= '0;
  endtask : xl

  task automatic settle;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic pulse_exc;
    @(posedge clk_i);
    arith_exc_i <= 1'b1;
    @(posedge clk_i);
    arith_exc_i <= 1'b0;
    @(negedge clk_i);
  endtask : pulse_exc
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) rd_seen <= reg_re_i;

  always @(negedge clk_i) begin
    if (rd_seen === 1'b1 && exp_rd.size() > 0) begin
      chk32(reg_rdata_o, exp_rd.pop_front());
    end else if (rst_n_i === 1'b1) begin
      chk32(reg_rdata_o, 32'h0);
    end
    if (resp_o.valid === 1'b1) begin
      if (exp_rsp.size() == 0) begin
        chk32(32'h1, 32'h0);
      end else begin
        chk_rsp(resp_o, exp_rsp.pop_front());
      end
    end
  end

  initial begin
    #80000;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(LAM_OFF_PSW1, LAM_P1_RESET);
    rd(LAM_OFF_PSW2, LAM_P2_RESET);
    rd(8'hfc, 32'h0);
    for (int i = 0; i < 4; i++) begin
      la = 19'($random(seed));
      xl(mkq(4'h0, la), G, {5'h00, la}, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      r = mkq(4'h0, 19'h00123);
      r.bit_op = 1'b1;
      r.bit_sel = 3'(i);
      xl(r, G, 24'h000123, 8'h80 >> i);
    end
    wr(LAM_OFF_PSW1, 32'h8400_0000);
    index_i <= 32'h0010_0000;
    xl(mkq(4'h2, 19'h00010), G, 24'h100010, 8'h00);
    xl(mkq(4'ha, 19'h00010), FF, 24'h0, 8'h00);
    wr(8'h80, 32'h0000_0002);
    xl(mkq(4'h4, 19'h00804), G, 24'h000804, 8'h00);
    wr(LAM_OFF_PSW1, 32'h0400_0000);
    xl(mkq(4'h4, 19'h00804), PR, 24'h0, 8'h00);
    xl(mkq(4'h4, 19'h01004), G, 24'h001004, 8'h00);
    wr(8'h40, 32'h8123_c045);
    wr(8'h60, 32'h8077_0000);
    for (int m = 1; m < 4; m++) begin
      wr(LAM_OFF_PSW2, {2'(m), 30'h0});
      settle();
      chk32({31'h0, mapped_o}, 32'h1);
    end
    wr(LAM_OFF_PSW2, 32'h6970_0000);
    settle();
    chk32({20'h0, base_process_index_o}, 32'h0000_0a5c);
    chk32({31'h0, extended_index_enable_o}, 32'h1);
    xl(mkq(4'h0, 19'h00010), G, {9'h123, 15'h0010}, 8'h00);
    xl(mkq(4'h8, 19'h08004), G, {9'h045, 15'h0004}, 8'h00);
    xl(mkq(4'h4, 19'h08004), PR, 24'h0, 8'h00);
    xl(mkq(4'h0, 19'h10000), PG, 24'h0, 8'h00);
    xl(mkq(4'h1, 19'h00020), G, {9'h077, 15'h0020}, 8'h00);
    xl(mkq(4'h9, 19'h00020), FF, 24'h0, 8'h00);
    wr(LAM_OFF_PSW1, 32'h8000_0000);
    xl(mkq(4'h4, 19'h08004), G, {9'h045, 15'h0004}, 8'h00);
    wr(LAM_OFF_PSW1, 32'h0);
    xl(mkq(4'h1, 19'h00020), PG, 24'h0, 8'h00);
    wr(LAM_OFF_PSW2, 32'h0);
    rd(8'h40, 32'h8123_c045);
    xl(mkq(4'h0, 19'h08004), G, 24'h008004, 8'h00);
    @(posedge clk_i);
    br_valid_i <= 1'b1;
    br_indirect_i <= 1'b1;
    br_target_i <= 19'h2468a;
    br_ind_word_i <= 32'h5000_0000;
    @(posedge clk_i);
    br_valid_i <= 1'b0;
    settle();
    chk32({31'h0, next_right_halfword_flag_o}, 32'h1);
    rd(LAM_OFF_PSW1, {1'b0, 4'ha, 8'h00, 18'h12345, 1'b0});
    sdw_mode_i <= 1'b1;
    blocked_i <= 1'b1;
    wr(LAM_OFF_PSW1, 32'hffc7_ffff);
    rd(LAM_OFF_PSW1, 32'hff87_ffff);
    settle();
    chk32(psw1_mem_o, 32'hff07_fffe);
    chk32({31'h0, privileged_flag_o}, 32'h1);
    pulse_exc();
    chk32({31'h0, arith_trap_o}, 32'h1);
    wr(LAM_OFF_PSW1, 32'h8000_0000);
    pulse_exc();
    chk32({31'h0, arith_trap_o}, 32'h0);
    @(posedge clk_i);
    save_old_i <= 1'b1;
    last_right_i <= 1'b1;
    @(posedge clk_i);
    save_old_i <= 1'b0;
    rd(LAM_OFF_OLD, 32'h8200_0000);
    // A write while the enable is low must leave the mode unmapped.
    @(posedge clk_i);
    en_i <= 1'b0;
    reg_we_i <= 1'b1;
    reg_addr_i <= LAM_OFF_PSW2;
    reg_wdata_i <= 32'h4000_0000;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    en_i <= 1'b1;
    settle();
    chk32({31'h0, mapped_o}, 32'h0);
    repeat (4) @(posedge clk_i);
    chk32({16'h0, grant_cnt}, 32'(exp_grants));
    end_of_test();
  end
endmodule : test_lam_mapper
